// *** design/lsc_combiner.sv ***
// Logic state combiner: inputs, keys, marks, states, APB registers.
// Assumes inputs synchronous to pclk and an APB master that waits for pready.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "lsc_map.svh"
`default_nettype none
module lsc_combiner #(
    parameter int unsigned MS_CYCLES = `LSC_MS_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data inputs
    input wire logic [15:0] in0,
    input wire logic [15:0] in1,
    input wire logic [15:0] in2,
    input wire logic ext_strobe,
    // Results
    output logic [3:0] state_out,
    output logic [15:0] aux_out,
    output logic [15:0] aux_saved,
    output logic aux_save_pulse
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [13:0] ctrl;
    logic [15:0] stb_period;
    logic [4:0] rst_key;
    logic [15:0] in_gain [3];
    logic [4:0] in_width [3];
    logic in_deb_en [3];
    logic [15:0] in_care [3];
    logic [15:0] in_deb_time [3];
    logic [2:0] key_cfg [12];
    logic [31:0] key_pat [12];
    logic [18:0] mark_cfg [6];
    logic [15:0] mark_to [6];
    logic [14:0] st_cfg [4];

    function automatic logic [15:0] width_mask(input logic [4:0] w);
        width_mask = (w >= 5'd16) ? 16'hffff : 16'((17'h1 << w) - 17'h1);
    endfunction

    // Operand codes: 0 blank, 1..12 key, 13..18 mark; returns {used, value}
    function automatic logic [1:0] op_get(input logic [4:0] c,
        input logic [11:0] k, input logic [5:0] m);
        op_get = 2'b00;
        if (c >= 5'd1 && c <= 5'd12) op_get = {1'b1, k[4'(c - 5'd1)]};
        else if (c >= 5'd13 && c <= 5'd18) op_get = {1'b1, m[3'(c - 5'd13)]};
    endfunction

    wire lsc_pkg::lsc_stb_t stb_src = lsc_pkg::lsc_stb_t'(ctrl[1:0]);
    wire lsc_pkg::lsc_aux_t aux_kind = lsc_pkg::lsc_aux_t'(ctrl[3:2]);
    wire [1:0] aux_sel = ctrl[5:4];
    wire save_en = ctrl[`LSC_CTRL_SAVE];
    wire [1:0] word_sel = ctrl[9:8];
    wire [3:0] st_en = ctrl[`LSC_CTRL_ST_EN+:4];

    wire wr = psel && penable && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            stb_period <= `LSC_RST_PERIOD;
            rst_key <= '0;
            for (int i = 0; i < 3; i++) begin
                in_gain[i] <= `LSC_RST_GAIN;
                in_width[i] <= `LSC_RST_WIDTH;
                in_deb_en[i] <= 1'b0;
                in_care[i] <= `LSC_RST_CARE;
                in_deb_time[i] <= '0;
            end
            for (int i = 0; i < 12; i++) begin
                key_cfg[i] <= '0;
                key_pat[i] <= '0;
            end
            for (int i = 0; i < 6; i++) begin
                mark_cfg[i] <= '0;
                mark_to[i] <= '0;
            end
            for (int i = 0; i < 4; i++) st_cfg[i] <= '0;
        end else if (wr) begin
            if (paddr == `LSC_A_CTRL) ctrl <= pwdata[13:0];
            if (paddr == `LSC_A_STB_PERIOD) stb_period <= pwdata[15:0];
            if (paddr == `LSC_A_RST_KEY) rst_key <= pwdata[4:0];
            for (int i = 0; i < 3; i++) begin
                if (paddr == `LSC_A_IN_CFG + 12'(4 * i)) begin
                    in_gain[i] <= pwdata[15:0];
                    in_width[i] <= pwdata[20:16];
                    in_deb_en[i] <= pwdata[`LSC_IN_DEB_EN];
                end
                if (paddr == `LSC_A_IN_CARE + 12'(4 * i)) in_care[i] <= pwdata[15:0];
                if (paddr == `LSC_A_IN_DEB + 12'(4 * i)) in_deb_time[i] <= pwdata[15:0];
            end
            for (int i = 0; i < 12; i++) begin
                if (paddr == `LSC_A_KEY_CFG + 12'(4 * i)) key_cfg[i] <= pwdata[2:0];
                if (paddr == `LSC_A_KEY_PAT + 12'(4 * i)) key_pat[i] <= pwdata;
            end
            for (int i = 0; i < 6; i++) begin
                if (paddr == `LSC_A_MARK_CFG + 12'(4 * i)) mark_cfg[i] <= pwdata[18:0];
                if (paddr == `LSC_A_MARK_TO + 12'(4 * i)) mark_to[i] <= pwdata[15:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (paddr == `LSC_A_ST_CFG + 12'(4 * i)) st_cfg[i] <= pwdata[14:0];
            end
        end
    end

    // ----------------------------------------
    // Input conditioning and debounce
    // ----------------------------------------
    wire [15:0] in_raw [3];
    logic [15:0] cond [3];
    logic [15:0] db_prev [3];
    logic [15:0] db_cnt [3];
    logic [15:0] db_val [3];
    assign in_raw[0] = in0;
    assign in_raw[1] = in1;
    assign in_raw[2] = in2;

    for (genvar i = 0; i < 3; i++) begin : g_in
        // Integer product truncated to the input width
        wire [31:0] prod = in_raw[i] * in_gain[i];
        assign cond[i] = prod[15:0] & width_mask(in_width[i]) & in_care[i];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                db_prev[i] <= '0;
                db_cnt[i] <= '0;
                db_val[i] <= '0;
            end else if (!in_deb_en[i]) begin
                db_prev[i] <= cond[i];
                db_val[i] <= cond[i];
            end else if (cond[i] != db_prev[i]) begin
                db_prev[i] <= cond[i];
                db_cnt[i] <= '0;
            end else if (db_cnt[i] < in_deb_time[i]) begin
                db_cnt[i] <= db_cnt[i] + 16'h0001;
            end else begin
                db_val[i] <= cond[i];
            end
        end
    end

    // ----------------------------------------
    // Strobe sources
    // ----------------------------------------
    logic [31:0] ms_cnt;
    logic [15:0] per_cnt;
    logic ms_tick, tmr_pls, ext_q;
    logic [15:0] in1_q;
    wire chg_pls = db_val[0] != in1_q;
    wire ext_rise = ext_strobe && !ext_q;
    wire stb_evt = (stb_src == lsc_pkg::LSC_STB_TIMER) ? tmr_pls :
                   (stb_src == lsc_pkg::LSC_STB_EXT) ? ext_rise :
                   (stb_src == lsc_pkg::LSC_STB_CHANGE) ? chg_pls : 1'b0;
    // Timer and change strobes are pulses; the external strobe is a level
    wire ev = (stb_src == lsc_pkg::LSC_STB_NONE) ? 1'b1 :
              (stb_src == lsc_pkg::LSC_STB_EXT) ? ext_strobe : stb_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
            per_cnt <= '0;
            tmr_pls <= 1'b0;
            ext_q <= 1'b0;
            in1_q <= '0;
        end else begin
            ms_tick <= ms_cnt == MS_CYCLES - 1;
            ms_cnt <= (ms_cnt == MS_CYCLES - 1) ? '0 : ms_cnt + 32'h1;
            tmr_pls <= ms_tick && (per_cnt + 16'h1 >= stb_period);
            if (ms_tick) per_cnt <= (per_cnt + 16'h1 >= stb_period) ? '0 : per_cnt + 16'h1;
            ext_q <= ext_strobe;
            in1_q <= db_val[0];
        end
    end

    // ----------------------------------------
    // Keys, marks, states
    // ----------------------------------------
    logic [11:0] key_now, key_q;
    logic [5:0] mark_now, mark_q;
    logic [3:0] st_now;
    logic [15:0] key_src [12];
    logic [15:0] to_cnt [6];

    for (genvar k = 0; k < 12; k++) begin : g_key
        wire [1:0] src = key_cfg[k][1:0];
        assign key_src[k] = (src == 2'd0) ? 16'h0000 : db_val[2'(src - 2'd1)];
        wire pat_ok = ((key_src[k] ^ key_pat[k][31:16]) & key_pat[k][15:0]) == 16'h0000;
        assign key_now[k] = (src != 2'd0) && (key_cfg[k][2] ? pat_ok : key_src[k] != 16'h0);
    end

    wire [1:0] rst_op = op_get({1'b0, rst_key[3:0]}, key_now, 6'h00);
    wire rst_hit = rst_op[1] && (rst_op[0] ^ rst_key[4]);

    for (genvar m = 0; m < 6; m++) begin : g_mark
        logic [2:0] u, v;
        for (genvar j = 0; j < 3; j++) begin : g_op
            wire [4:0] c = mark_cfg[m][5*j+:5];
            wire [1:0] o = op_get({1'b0, c[3:0]}, key_now, 6'h00);
            assign u[j] = o[1];
            assign v[j] = o[1] && (o[0] ^ c[4]);
        end
        wire to_hit = (mark_to[m] != 16'h0) && (to_cnt[m] >= mark_to[m]);
        wire clr = v[1] || to_hit || (mark_cfg[m][`LSC_MARK_USE_RST] && rst_hit);
        wire onoff = mark_q[m] ? !clr : v[0];
        wire lsc_pkg::lsc_mark_t mt = lsc_pkg::lsc_mark_t'(mark_cfg[m][17:15]);
        always_comb begin
            case (mt)
                lsc_pkg::LSC_MK_ONOFF: mark_now[m] = onoff;
                lsc_pkg::LSC_MK_AND: mark_now[m] = (|u) && ((v | ~u) == 3'b111);
                lsc_pkg::LSC_MK_OR: mark_now[m] = |v;
                lsc_pkg::LSC_MK_XOR: mark_now[m] = $countones(v) == 1;
                default: mark_now[m] = 1'b0;
            endcase
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) to_cnt[m] <= '0;
            else if (!mark_q[m]) to_cnt[m] <= '0;
            else if (ms_tick && to_cnt[m] != 16'hffff) to_cnt[m] <= to_cnt[m] + 16'h1;
        end
    end

    for (genvar s = 0; s < 4; s++) begin : g_st
        logic [2:0] u, v;
        for (genvar j = 0; j < 3; j++) begin : g_op
            wire [1:0] o = op_get(st_cfg[s][5*j+:5], key_now, mark_now);
            assign u[j] = o[1];
            assign v[j] = o[0];
        end
        assign st_now[s] = st_en[s] && (|u) && ((v | ~u) == 3'b111);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_q <= '0;
            mark_q <= '0;
            state_out <= '0;
        end else if (ev) begin
            key_q <= key_now;
            mark_q <= mark_now;
            state_out <= st_now;
        end
    end

    // ----------------------------------------
    // Aux output and save on strobe
    // ----------------------------------------
    wire [15:0] word = (word_sel == 2'd0) ? {4'h0, key_q} :
                       (word_sel == 2'd1) ? {10'h000, mark_q} : {12'h000, state_out};
    wire [15:0] next_aux = (aux_kind == lsc_pkg::LSC_AUX_INPUT) ? db_val[aux_sel] :
                           (aux_kind == lsc_pkg::LSC_AUX_WORD) ? word : 16'h0000;
    wire save_now = save_en && (stb_src != lsc_pkg::LSC_STB_NONE) && stb_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_out <= '0;
            aux_saved <= '0;
            aux_save_pulse <= 1'b0;
        end else begin
            aux_out <= next_aux;
            aux_save_pulse <= save_now;
            if (save_now) aux_saved <= next_aux;
        end
    end

    // ----------------------------------------
    // APB read: two-cycle access phase, registered data
    // ----------------------------------------
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            `LSC_A_CTRL: rd_val = {18'h0, ctrl};
            `LSC_A_STB_PERIOD: rd_val = {16'h0, stb_period};
            `LSC_A_RST_KEY: rd_val = {27'h0, rst_key};
            `LSC_A_STATUS: rd_val = {10'h0, state_out, mark_q, key_q};
            `LSC_A_AUX_SAVED: rd_val = {16'h0, aux_saved};
            default: rd_hit = 1'b0;
        endcase
        for (int i = 0; i < 3; i++) begin
            if (paddr == `LSC_A_IN_CFG + 12'(4 * i)) begin
                rd_val = {7'h0, in_deb_en[i], 3'h0, in_width[i], in_gain[i]};
                rd_hit = 1'b1;
            end
            if (paddr == `LSC_A_IN_CARE + 12'(4 * i)) begin
                rd_val = {16'h0, in_care[i]};
                rd_hit = 1'b1;
            end
            if (paddr == `LSC_A_IN_DEB + 12'(4 * i)) begin
                rd_val = {16'h0, in_deb_time[i]};
                rd_hit = 1'b1;
            end
        end
        for (int i = 0; i < 12; i++) begin
            if (paddr == `LSC_A_KEY_CFG + 12'(4 * i)) begin
                rd_val = {29'h0, key_cfg[i]};
                rd_hit = 1'b1;
            end
            if (paddr == `LSC_A_KEY_PAT + 12'(4 * i)) begin
                rd_val = key_pat[i];
                rd_hit = 1'b1;
            end
        end
        for (int i = 0; i < 6; i++) begin
            if (paddr == `LSC_A_MARK_CFG + 12'(4 * i)) begin
                rd_val = {13'h0, mark_cfg[i]};
                rd_hit = 1'b1;
            end
            if (paddr == `LSC_A_MARK_TO + 12'(4 * i)) begin
                rd_val = {16'h0, mark_to[i]};
                rd_hit = 1'b1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (paddr == `LSC_A_ST_CFG + 12'(4 * i)) begin
                rd_val = {17'h0, st_cfg[i]};
                rd_hit = 1'b1;
            end
        end
    end

    wire acc = psel && penable && !pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            prdata <= (acc && !pwrite) ? rd_val : 32'h0;
            pslverr <= acc && !rd_hit;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_deb_bounce;
        in_deb_en[0] && cond[0] != db_prev[0];
    endsequence

    a_eval_every_tick: assert property (stb_src == lsc_pkg::LSC_STB_NONE
        |=> state_out == $past(st_now)) else $error("state not refreshed");
    a_hold_no_strobe: assert property (stb_src != lsc_pkg::LSC_STB_NONE && !ev
        |=> $stable(state_out) && $stable(key_q)) else $error("update without strobe");
    a_ext_strobe_eval: assert property (stb_src == lsc_pkg::LSC_STB_EXT && ext_strobe
        |=> state_out == $past(st_now)) else $error("external strobe ignored");
    a_debounce_hold: assert property (s_deb_bounce
        |=> db_val[0] == $past(db_val[0])) else $error("bounce passed");
    a_debounce_restart: assert property (s_deb_bounce
        |=> db_cnt[0] == 16'h0) else $error("counter not restarted");
    a_key_truth: assert property (ev && key_cfg[0][1:0] != 2'd0 && !key_cfg[0][2]
        |=> key_q[0] == ($past(key_src[0]) != 16'h0)) else $error("truth test");
    a_key_mask: assert property (ev && key_cfg[0][1:0] != 2'd0 && key_cfg[0][2]
        |=> key_q[0] == ((($past(key_src[0]) ^ $past(key_pat[0][31:16]))
            & $past(key_pat[0][15:0])) == 16'h0)) else $error("mask test");
    a_aux_pass: assert property (aux_kind == lsc_pkg::LSC_AUX_INPUT
        |=> aux_out == $past(db_val[aux_sel])) else $error("aux pass wrong");
    a_aux_save: assert property (aux_save_pulse
        |-> aux_saved == aux_out && $past(stb_evt)) else $error("aux save wrong");
    a_state_enable: assert property (!st_en[0] && ev
        |=> !state_out[0]) else $error("disabled state high");
endmodule
`default_nettype wire

// *** design/lsc_map.svh ***
// Register offsets, field positions, reset values and timing counts
// for the logic state combiner. Assumes a 12-bit APB byte address.
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define LSC_A_CTRL 12'h000
`define LSC_A_STB_PERIOD 12'h004
`define LSC_A_RST_KEY 12'h008
`define LSC_A_STATUS 12'h00c
`define LSC_A_AUX_SAVED 12'h010
`define LSC_A_IN_CFG 12'h020
`define LSC_A_IN_CARE 12'h030
`define LSC_A_IN_DEB 12'h040
`define LSC_A_KEY_CFG 12'h080
`define LSC_A_KEY_PAT 12'h0c0
`define LSC_A_MARK_CFG 12'h100
`define LSC_A_MARK_TO 12'h120
`define LSC_A_ST_CFG 12'h140
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define LSC_CTRL_SAVE 6
`define LSC_CTRL_ST_EN 10
`define LSC_IN_DEB_EN 24
`define LSC_MARK_USE_RST 18
`define LSC_RST_GAIN 16'h0001
`define LSC_RST_WIDTH 5'h10
`define LSC_RST_CARE 16'hffff
`define LSC_RST_PERIOD 16'h0064
// ----------------------------------------
// Timing
// ----------------------------------------
`define LSC_CLK_NS 25
`define LSC_MS_NS 1000000
`define LSC_MS_CYCLES (`LSC_MS_NS / `LSC_CLK_NS)
`endif

// *** design/lsc_pkg.sv ***
// Types shared by the logic state combiner.
// Assumes nothing of its surroundings.
`default_nettype none
package lsc_pkg;
    typedef enum logic [1:0] {
        LSC_STB_NONE = 2'b00,
        LSC_STB_TIMER = 2'b01,
        LSC_STB_EXT = 2'b10,
        LSC_STB_CHANGE = 2'b11
    } lsc_stb_t;
    typedef enum logic [1:0] {
        LSC_AUX_OFF = 2'b00,
        LSC_AUX_INPUT = 2'b01,
        LSC_AUX_WORD = 2'b10
    } lsc_aux_t;
    typedef enum logic [2:0] {
        LSC_MK_NONE = 3'b000,
        LSC_MK_ONOFF = 3'b001,
        LSC_MK_AND = 3'b010,
        LSC_MK_OR = 3'b011,
        LSC_MK_XOR = 3'b100
    } lsc_mark_t;
endpackage
`default_nettype wire

// *** test/lsc_src_model.sv ***
// Upstream source model: drives the three data inputs and the strobe.
// Assumes the bench posts wanted values; they land after a rising edge.
`default_nettype none
module lsc_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Wanted values from the bench
    input wire logic [15:0] want0,
    input wire logic [15:0] want1,
    input wire logic [15:0] want2,
    input wire logic want_stb,
    input wire logic bounce,
    // Drive into the block
    output logic [15:0] in0,
    output logic [15:0] in1,
    output logic [15:0] in2,
    output logic ext_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // A contact that bounces flips bit 0 every cycle, never stable long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in0 <= 16'h0000;
            in1 <= 16'h0000;
            in2 <= 16'h0000;
            ext_strobe <= 1'b0;
        end else begin
            in0 <= bounce ? (in0 ^ 16'h0001) : want0;
            in1 <= want1;
            in2 <= want2;
            ext_strobe <= want_stb;
        end
    end
endmodule
`default_nettype wire

// *** test/lsc_combiner_tb.sv ***
// Self-checking bench for the logic state combiner.
// Assumes the block's APB slave and the upstream source model.
`include "lsc_map.svh"
`default_nettype none
module lsc_combiner_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] w0 = 16'h0;
    logic [15:0] w1 = 16'h0;
    logic [15:0] w2 = 16'h0;
    logic wstb = 1'b0;
    logic bnc = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, ext_strobe, aux_save_pulse, er;
    logic [15:0] in0, in1, in2, aux_out, aux_saved;
    logic [3:0] state_out;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rises = 0;
    int saves = 0;
    // ----
    // Design and upstream source
    // ----
    lsc_combiner #(.MS_CYCLES(10)) lsc_combiner_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .in0(in0), .in1(in1),
        .in2(in2), .ext_strobe(ext_strobe), .state_out(state_out), .aux_out(aux_out),
        .aux_saved(aux_saved), .aux_save_pulse(aux_save_pulse));
    lsc_src_model lsc_src_model_inst (.pclk(pclk), .presetn(presetn), .want0(w0),
        .want1(w1), .want2(w2), .want_stb(wstb), .bounce(bnc), .in0(in0), .in1(in1),
        .in2(in2), .ext_strobe(ext_strobe));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // Counts state one onsets, so a bounce that leaks shows as extra rises
    always @(posedge state_out[0]) rises++;
    // Counts save pulses, so a save outside a strobe or with saving off shows
    always @(posedge aux_save_pulse) saves++;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ----
    // Shared tasks
    // ----
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(name, e, rd);
    endtask
    task automatic put(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        w0 <= a;
        w1 <= b;
        w2 <= c;
        repeat (6) @(posedge pclk);
    endtask
    task automatic st(input logic [3:0] e);
        chk("state_out", {28'h0, e}, {28'h0, state_out});
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        st(4'h0);
        rdc("ctrl", `LSC_A_CTRL, 32'h0);
        rdc("in_cfg", `LSC_A_IN_CFG + 12'h008, 32'h0010_0001);
        rdc("in_care", `LSC_A_IN_CARE, 32'h0000_ffff);
        rdc("period", `LSC_A_STB_PERIOD, 32'h0000_0064);
        rdc("unmapped", 12'hffc, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        wr(`LSC_A_STATUS, 32'hffff_ffff);
        rdc("status_ro", `LSC_A_STATUS, 32'h0);
    endtask
    task automatic t_keys();
        wr(`LSC_A_CTRL, 32'h0000_0c00);
        wr(`LSC_A_KEY_CFG, 32'h1);
        wr(`LSC_A_KEY_CFG + 12'h004, 32'h5);
        wr(`LSC_A_KEY_PAT + 12'h004, 32'h0005_000f);
        wr(`LSC_A_ST_CFG, 32'h1);
        wr(`LSC_A_ST_CFG + 12'h004, 32'h2);
        put(16'h0000, 16'h0, 16'h0);
        st(4'h0);
        put(16'h1235, 16'h0, 16'h0);
        st(4'h3);
        rdc("status", `LSC_A_STATUS, 32'h000c_0003);
        put(16'h1234, 16'h0, 16'h0);
        st(4'h1);
        wr(`LSC_A_IN_CFG, 32'h0004_0001);
        put(16'h0010, 16'h0, 16'h0);
        st(4'h0);
        wr(`LSC_A_IN_CFG, 32'h0010_0002);
        put(16'h8000, 16'h0, 16'h0);
        st(4'h0);
        put(16'h4000, 16'h0, 16'h0);
        st(4'h1);
        wr(`LSC_A_IN_CFG, 32'h0010_0001);
        wr(`LSC_A_IN_CARE, 32'h0000_fff0);
        put(16'h0005, 16'h0, 16'h0);
        st(4'h0);
        wr(`LSC_A_IN_CARE, 32'h0000_ffff);
    endtask
    task automatic t_marks();
        logic e;
        wr(`LSC_A_CTRL, 32'h0000_0400);
        wr(`LSC_A_KEY_CFG + 12'h004, 32'h2);
        wr(`LSC_A_KEY_CFG + 12'h008, 32'h3);
        wr(`LSC_A_ST_CFG, 32'hd);
        for (int t = 2; t <= 4; t++) begin
            wr(`LSC_A_MARK_CFG, 32'(t << 15) | 32'h0000_0c41);
            for (int v = 0; v < 8; v++) begin
                put({15'h0, v[0]}, {15'h0, v[1]}, {15'h0, v[2]});
                e = (t == 2) ? (v == 7) : (t == 3) ? (v != 0) : ($countones(v) == 1);
                st({3'h0, e});
            end
        end
        wr(`LSC_A_MARK_CFG, 32'h0001_0011);
        put(16'h0, 16'h0, 16'h0);
        st(4'h1);
        wr(`LSC_A_MARK_CFG, 32'h0);
        wr(`LSC_A_MARK_TO, 32'h3);
        wr(`LSC_A_MARK_CFG, 32'h0000_8041);
        st(4'h0);
        put(16'h1, 16'h0, 16'h0);
        put(16'h0, 16'h0, 16'h0);
        st(4'h1);
        put(16'h0, 16'h1, 16'h0);
        st(4'h0);
        put(16'h1, 16'h0, 16'h0);
        put(16'h0, 16'h0, 16'h0);
        st(4'h1);
        repeat (30) @(posedge pclk);
        st(4'h0);
        wr(`LSC_A_MARK_TO, 32'h0);
        wr(`LSC_A_RST_KEY, 32'h3);
        wr(`LSC_A_MARK_CFG, 32'h0004_8041);
        put(16'h1, 16'h0, 16'h0);
        put(16'h0, 16'h0, 16'h0);
        repeat (40) @(posedge pclk);
        st(4'h1);
        put(16'h0, 16'h0, 16'h1);
        st(4'h0);
        wr(`LSC_A_ST_CFG, 32'h1);
    endtask
    task automatic t_strobe();
        wr(`LSC_A_CTRL, 32'h0000_0446);
        put(16'h0042, 16'h0, 16'h0);
        st(4'h0);
        chk("aux_out", 32'h42, {16'h0, aux_out});
        wstb <= 1'b1;
        repeat (6) @(posedge pclk);
        st(4'h1);
        chk("aux_saved", 32'h42, {16'h0, aux_saved});
        chk("save_pulses", 32'h1, 32'(saves));
        rdc("aux_saved_reg", `LSC_A_AUX_SAVED, 32'h42);
        wstb <= 1'b0;
        wr(`LSC_A_KEY_CFG, 32'h2);
        wr(`LSC_A_CTRL, 32'h0000_0403);
        put(16'h0042, 16'h0, 16'h0);
        st(4'h1);
        put(16'h0001, 16'h0, 16'h0);
        st(4'h0);
        put(16'h0001, 16'h1, 16'h0);
        st(4'h0);
        put(16'h0002, 16'h1, 16'h0);
        st(4'h1);
        wr(`LSC_A_STB_PERIOD, 32'h2);
        wr(`LSC_A_CTRL, 32'h0000_0401);
        put(16'h0002, 16'h0, 16'h0);
        repeat (25) @(posedge pclk);
        st(4'h0);
        wr(`LSC_A_CTRL, 32'h0000_0608);
        put(16'h0002, 16'h1, 16'h0);
        chk("aux_word", 32'h1, {16'h0, aux_out});
        wr(`LSC_A_CTRL, 32'h0000_0408);
        repeat (2) @(posedge pclk);
        chk("aux_keys", 32'h3, {16'h0, aux_out});
        chk("save_pulses", 32'h1, 32'(saves));
    endtask
    task automatic t_debounce();
        wr(`LSC_A_CTRL, 32'h0000_0400);
        wr(`LSC_A_KEY_CFG, 32'h1);
        wr(`LSC_A_IN_DEB, 32'h4);
        wr(`LSC_A_IN_CFG, 32'h0110_0001);
        put(16'h0, 16'h0, 16'h0);
        rises = 0;
        bnc <= 1'b1;
        repeat (9) @(posedge pclk);
        st(4'h0);
        bnc <= 1'b0;
        w0 <= 16'h0001;
        repeat (12) @(posedge pclk);
        st(4'h1);
        chk("onsets", 32'h1, 32'(rises));
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_keys();
        t_marks();
        t_strobe();
        t_debounce();
        give_verdict();
    end
endmodule
`default_nettype wire
